// ### hw/periph_irq_pkg.sv
package periph_irq_pkg;

  // register offsets on the plain port
  localparam logic [3:0] OFF_FLAGS_SECOND  = 4'h0;
  localparam logic [3:0] OFF_FLAGS_THIRD   = 4'h1;
  localparam logic [3:0] OFF_ENABLES_FIRST = 4'h2;
  localparam logic [3:0] OFF_ENABLES_SECOND = 4'h3;
  localparam logic [3:0] OFF_ENABLES_THIRD = 4'h4;
  localparam logic [3:0] OFF_IRQ_CONTROL   = 4'h5;
  localparam logic [3:0] OFF_IRQ_STATUS    = 4'h6;

  // reset values
  localparam logic [7:0] RST_FLAGS   = 8'h00;
  localparam logic [7:0] RST_ENABLES = 8'h00;
  localparam logic [1:0] RST_CONTROL = 2'h0;

  // second flag register bit positions
  localparam int BIT_OSC_FAIL       = 7;
  localparam int BIT_CMP_TWO        = 6;
  localparam int BIT_CMP_ONE        = 5;
  localparam int BIT_USB            = 4;
  localparam int BIT_SER1_COLLISION = 3;
  localparam int BIT_LOW_VOLTAGE    = 2;
  localparam int BIT_TMR3_OVERFLOW  = 1;
  localparam int BIT_CAPCOMP2       = 0;

  // third flag register bit positions
  localparam int BIT_SER2_DONE      = 7;
  localparam int BIT_SER2_COLLISION = 6;
  localparam int BIT_UART2_RECEIVE  = 5;
  localparam int BIT_UART2_TRANSMIT = 4;
  localparam int BIT_TMR4_MATCH     = 3;
  localparam int BIT_CAPCOMP5       = 2;
  localparam int BIT_CAPCOMP4       = 1;
  localparam int BIT_CAPCOMP3       = 0;

  // control register bit positions
  localparam int BIT_GLOBAL_ENABLE  = 0;
  localparam int BIT_PRIORITY_LEVELS = 1;

  // number of capture/compare units handled here (2,3,4,5)
  localparam int CAPCOMP_UNITS = 4;

  // operating mode of a capture/compare unit
  typedef enum logic [1:0] {
    MODE_OFF,
    MODE_CAPTURE,
    MODE_COMPARE,
    MODE_PWM
  } capcomp_mode_t;

  // one-cycle event pulses and levels from the peripherals
  typedef struct packed {
    logic                     osc_fail;
    logic                     cmp_two_out;
    logic                     cmp_one_out;
    logic                     usb_req;
    logic                     ser1_collision;
    logic                     lvd_trip;
    logic                     tmr3_overflow;
    logic                     ser2_done;
    logic                     ser2_collision;
    logic                     uart2_rx_full;
    logic                     uart2_tx_empty;
    logic                     tmr4_match;
    logic [CAPCOMP_UNITS-1:0] capture;
    logic [CAPCOMP_UNITS-1:0] compare;
  } periph_events_t;

endpackage : periph_irq_pkg

// ### hw/peripheral_irq_flag_enable.sv
// Added by the designer: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none

module peripheral_irq_flag_enable
  import periph_irq_pkg::*;
#(
  parameter int REG_WIDTH = 8
) (
  // clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rst,
  // register port
  input  wire logic [3:0]           reg_addr,
  input  wire logic [REG_WIDTH-1:0] reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic [REG_WIDTH-1:0]      reg_rdata,
  // peripheral events
  input  wire periph_events_t       events,
  input  wire capcomp_mode_t        capcomp_mode [CAPCOMP_UNITS],
  // first flag register, kept by another block
  input  wire logic [7:0]           flags_first,
  // priority of each source, 1 is high: {third, second, first}
  input  wire logic [23:0]          source_high_priority,
  // requests to the core
  output logic                      periph_irq,
  output logic                      periph_irq_high,
  output logic                      periph_irq_low
);

  // capture in capture mode or match in compare mode
  function automatic logic capcomp_hit(input capcomp_mode_t mode,
                                       input logic cap,
                                       input logic cmp);
    capcomp_hit = ((mode == MODE_CAPTURE) && cap) ||
                  ((mode == MODE_COMPARE) && cmp);
  endfunction : capcomp_hit

  // used for the plain request and for both priority halves,
  // so the three views of the sources stay consistent
  // or over sources that are both flagged and enabled
  function automatic logic any_pending(input logic [23:0] flags,
                                       input logic [23:0] enables,
                                       input logic [23:0] select);
    any_pending = |(flags & enables & select);
  endfunction : any_pending

  // the first flag register lives in another block and comes in
  // as a level; only its enables are kept here
  // flag and enable registers
  logic [7:0]           flags_second_ff;     // second flag register
  logic [7:0]           nxt_flags_second;
  logic [7:0]           flags_third_ff;      // third flag register
  logic [7:0]           nxt_flags_third;
  logic [7:0]           enables_first_ff;    // first enable register
  logic [7:0]           enables_second_ff;   // second enable register
  logic [7:0]           enables_third_ff;    // third enable register
  logic [1:0]           control_ff;          // global and priority enables

  // comparator change detection
  logic                 cmp_two_prev_ff;     // last comparator 2 output
  logic                 cmp_one_prev_ff;     // last comparator 1 output
  logic                 cmp_armed_ff;        // history valid after reset

  // request outputs and read data
  logic                 irq_ff;
  logic                 irq_high_ff;
  logic                 irq_low_ff;
  logic [REG_WIDTH-1:0] rdata_ff;
  logic [REG_WIDTH-1:0] nxt_rdata;

  // set requests per register
  logic [7:0]           set_second;
  logic [7:0]           set_third;
  logic [3:0]           capcomp_set;

  // combined vectors for gating
  logic [23:0]          all_flags;
  logic [23:0]          all_enables;
  logic                 global_enable;
  logic                 priority_levels;
  logic                 nxt_irq_high;
  logic                 nxt_irq_low;

  // the write strobe is one cycle long and the port never waits,
  // so each decode below acts for exactly one edge
  // decoded write strobes
  logic                 wr_flags_second;
  logic                 wr_flags_third;

  assign wr_flags_second = reg_wr && (reg_addr == OFF_FLAGS_SECOND);
  assign wr_flags_third  = reg_wr && (reg_addr == OFF_FLAGS_THIRD);

  assign global_enable   = control_ff[BIT_GLOBAL_ENABLE];
  assign priority_levels = control_ff[BIT_PRIORITY_LEVELS];

  // a unit in pwm mode still runs its match logic every period;
  // letting that reach the flag would raise a request on each
  // cycle of the waveform, so only capture and compare modes
  // may set a unit flag; off mode is treated the same way so a
  // unit that is being reconfigured stays quiet
  // capture/compare events, pwm and off modes never flag
  always_comb begin
    capcomp_set = 4'h0;
    for (int i = 0; i < CAPCOMP_UNITS; i++) begin
      capcomp_set[i] = capcomp_hit(capcomp_mode[i],
                                   events.capture[i],
                                   events.compare[i]);
    end
  end

  // every set term is a pulse or level from logic on mclk, so no
  // synchroniser sits in front; a source held high keeps setting
  // its flag and software cannot clear it until the source lets
  // go, which is what polling code expects
  // the comparator terms compare against last cycle's level and
  // are masked until that history holds a real sample
  // set requests for the second flag register
  always_comb begin
    set_second = 8'h00;
    set_second[BIT_OSC_FAIL] = events.osc_fail;
    set_second[BIT_CMP_TWO] = cmp_armed_ff &&
                              (events.cmp_two_out != cmp_two_prev_ff);
    set_second[BIT_CMP_ONE] = cmp_armed_ff &&
                              (events.cmp_one_out != cmp_one_prev_ff);
    set_second[BIT_USB] = events.usb_req;
    set_second[BIT_SER1_COLLISION] = events.ser1_collision;
    set_second[BIT_LOW_VOLTAGE] = events.lvd_trip;
    set_second[BIT_TMR3_OVERFLOW] = events.tmr3_overflow;
    set_second[BIT_CAPCOMP2] = capcomp_set[0];
  end

  // bits 5 and 4 have no set term here; the uart levels drive
  // them directly in the next-value logic below
  // set requests for the third flag register
  always_comb begin
    set_third = 8'h00;
    set_third[BIT_SER2_DONE] = events.ser2_done;
    set_third[BIT_SER2_COLLISION] = events.ser2_collision;
    set_third[BIT_TMR4_MATCH] = events.tmr4_match;
    set_third[BIT_CAPCOMP3] = capcomp_set[1];
    set_third[BIT_CAPCOMP4] = capcomp_set[2];
    set_third[BIT_CAPCOMP5] = capcomp_set[3];
  end

  // software write and hardware set meet here; the write is
  // applied first and the set ored on top, so an event that
  // lands in the same cycle as a clearing write is never lost
  // writing a 1 sets the flag, which lets software test the
  // request path without a live source
  // next value of the second flag register
  always_comb begin
    nxt_flags_second = flags_second_ff;
    // software write stores, writing 0 clears
    if (wr_flags_second) begin
      nxt_flags_second = reg_wdata[7:0];
    end
    nxt_flags_second = nxt_flags_second | set_second;
  end

  // the two uart bits are overridden after the write and set
  // terms: they only follow the buffer levels, so a write to
  // them is dropped and no stale 1 survives once the receive
  // buffer drains or the transmit buffer fills
  // next value of the third flag register
  always_comb begin
    nxt_flags_third = flags_third_ff;
    if (wr_flags_third) begin
      nxt_flags_third = reg_wdata[7:0];
    end
    nxt_flags_third = nxt_flags_third | set_third;
    nxt_flags_third[BIT_UART2_RECEIVE] = events.uart2_rx_full;
    nxt_flags_third[BIT_UART2_TRANSMIT] = events.uart2_tx_empty;
  end

  // each flag register has its own process so a fault in one
  // cannot hold the other; both clear together on reset
  // second flag register, set wins over a clearing write
  always_ff @(posedge mclk) begin
    if (rst) begin
      flags_second_ff <= RST_FLAGS;
    end else begin
      flags_second_ff <= nxt_flags_second;
    end
  end

  // third flag register
  always_ff @(posedge mclk) begin
    if (rst) begin
      flags_third_ff <= RST_FLAGS;
    end else begin
      flags_third_ff <= nxt_flags_third;
    end
  end

  // the history is cleared by reset rather than loaded, and the
  // armed bit keeps the first sample after release from being
  // taken as a change when a comparator output sits high
  // comparator history, first cycle after reset only loads
  always_ff @(posedge mclk) begin
    if (rst) begin
      cmp_two_prev_ff <= 1'b0;
      cmp_one_prev_ff <= 1'b0;
      cmp_armed_ff    <= 1'b0;
    end else begin
      cmp_two_prev_ff <= events.cmp_two_out;
      cmp_one_prev_ff <= events.cmp_one_out;
      cmp_armed_ff    <= 1'b1;
    end
  end

  // enables never touch the flags; they only gate the request
  // below, so a source can be polled with its enable off and
  // switched to interrupt mode later without losing an event
  // enable registers, plain read/write storage
  always_ff @(posedge mclk) begin
    if (rst) begin
      enables_first_ff  <= RST_ENABLES;
      enables_second_ff <= RST_ENABLES;
      enables_third_ff  <= RST_ENABLES;
    end else if (reg_wr) begin
      case (reg_addr)
        OFF_ENABLES_FIRST: begin
          enables_first_ff <= reg_wdata[7:0];
        end
        OFF_ENABLES_SECOND: begin
          enables_second_ff <= reg_wdata[7:0];
        end
        OFF_ENABLES_THIRD: begin
          enables_third_ff <= reg_wdata[7:0];
        end
        default: begin
          // other offsets leave enables alone
        end
      endcase
    end
  end

  // both control bits reset to 0, so after power-up nothing
  // reaches the core until software opens the path
  // global enable and priority mode
  always_ff @(posedge mclk) begin
    if (rst) begin
      control_ff <= RST_CONTROL;
    end else if (reg_wr && (reg_addr == OFF_IRQ_CONTROL)) begin
      control_ff <= reg_wdata[1:0];
    end
  end

  // flags and enables laid out as {third, second, first}
  assign all_flags   = {flags_third_ff, flags_second_ff, flags_first};
  assign all_enables = {enables_third_ff, enables_second_ff,
                        enables_first_ff};

  // without priority levels every source shares one request and
  // the global enable is the only master switch
  // with priority levels the high sources go straight through,
  // their masking belongs to the core side, while the global
  // enable now only holds back the low sources
  // the per-source priority comes in as a level from the block
  // that keeps the priority registers
  // split pending requests by priority
  always_comb begin
    nxt_irq_high = 1'b0;
    nxt_irq_low  = 1'b0;
    if (priority_levels) begin
      // high sources bypass the global enable
      nxt_irq_high = any_pending(all_flags, all_enables,
                                 source_high_priority);
      nxt_irq_low  = global_enable &&
                     any_pending(all_flags, all_enables,
                                 ~source_high_priority);
    end else begin
      nxt_irq_low  = global_enable &&
                     any_pending(all_flags, all_enables, 24'hFFFFFF);
    end
  end

  // the requests are registered so the core sees a clean level
  // with no glitch from the wide and-or tree; the cost is one
  // cycle between the flag rising and the request rising
  // registered requests to the core
  always_ff @(posedge mclk) begin
    if (rst) begin
      irq_ff      <= 1'b0;
      irq_high_ff <= 1'b0;
      irq_low_ff  <= 1'b0;
    end else begin
      irq_ff      <= nxt_irq_high || nxt_irq_low;
      irq_high_ff <= nxt_irq_high;
      irq_low_ff  <= nxt_irq_low;
    end
  end

  // the status offset shows the registered requests, the same
  // values the core sees, so software can tell which level is
  // pending; writes to it and to unmapped offsets are dropped
  // read data mux, unmapped offsets read zero
  always_comb begin
    nxt_rdata = '0;
    case (reg_addr)
      OFF_FLAGS_SECOND: begin
        nxt_rdata[7:0] = flags_second_ff;
      end
      OFF_FLAGS_THIRD: begin
        nxt_rdata[7:0] = flags_third_ff;
      end
      OFF_ENABLES_FIRST: begin
        nxt_rdata[7:0] = enables_first_ff;
      end
      OFF_ENABLES_SECOND: begin
        nxt_rdata[7:0] = enables_second_ff;
      end
      OFF_ENABLES_THIRD: begin
        nxt_rdata[7:0] = enables_third_ff;
      end
      OFF_IRQ_CONTROL: begin
        nxt_rdata[1:0] = control_ff;
      end
      OFF_IRQ_STATUS: begin
        // live request state
        nxt_rdata[2:0] = {irq_low_ff, irq_high_ff, irq_ff};
      end
      default: begin
        nxt_rdata = '0;
      end
    endcase
  end

  // read data falls back to zero outside the read slot so a
  // shared read bus can or this port with its neighbours
  // read data stands only in the cycle after the strobe
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_ff <= '0;
    end else if (reg_rd) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= '0;
    end
  end

  // all outputs come straight from flip-flops
  // outputs
  assign reg_rdata       = rdata_ff;
  assign periph_irq      = irq_ff;
  assign periph_irq_high = irq_high_ff;
  assign periph_irq_low  = irq_low_ff;

endmodule : peripheral_irq_flag_enable

`default_nettype wire

// ### verif/periph_irq_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module periph_irq_monitor
  import periph_irq_pkg::*;
#(
  parameter int REG_WIDTH = 8
) (
  // clock and reset
  input wire logic                 mclk,
  input wire logic                 rst,
  // register port
  input wire logic [3:0]           reg_addr,
  input wire logic [REG_WIDTH-1:0] reg_wdata,
  input wire logic                 reg_wr,
  input wire logic                 reg_rd,
  input wire logic [REG_WIDTH-1:0] reg_rdata,
  // events and requests
  input wire periph_events_t       events,
  input wire logic                 periph_irq,
  input wire logic                 periph_irq_high,
  input wire logic                 periph_irq_low
);
  // one clock domain, reset masks every check
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_reset_quiet: assert property ($fell(rst) |-> !periph_irq && reg_rdata == '0)
    else $error("outputs not clear after reset");
  a_idle_zero: assert property (!reg_rd |=> reg_rdata == '0)
    else $error("read data outside its read slot");
  a_unmapped_zero: assert property (reg_rd && reg_addr > 4'h6 |=> reg_rdata == '0)
    else $error("unmapped read not zero");
  a_irq_joined: assert property (periph_irq == (periph_irq_high || periph_irq_low))
    else $error("request is not the join of both levels");
  a_enable_back: assert property (reg_wr && reg_addr == OFF_ENABLES_FIRST ##1 !reg_wr
    ##1 reg_rd && reg_addr == OFF_ENABLES_FIRST |=> reg_rdata == $past(reg_wdata, 3))
    else $error("enable register lost written value");
  a_uart_mirror: assert property (reg_rd && reg_addr == OFF_FLAGS_THIRD && !$past(rst)
    && $stable(events.uart2_rx_full) && $stable(events.uart2_tx_empty)
    |=> reg_rdata[5] == $past(events.uart2_rx_full) && reg_rdata[4] == $past(events.uart2_tx_empty))
    else $error("uart flags do not follow buffer levels");
  a_osc_flag: assert property (events.osc_fail ##1 reg_rd && reg_addr == OFF_FLAGS_SECOND
    |=> reg_rdata[BIT_OSC_FAIL])
    else $error("oscillator flag not set");
  a_timer4_flag: assert property (events.tmr4_match ##1 reg_rd && reg_addr == OFF_FLAGS_THIRD
    |=> reg_rdata[BIT_TMR4_MATCH])
    else $error("timer 4 flag not set");

  // main scenarios reached
  c_high: cover property (periph_irq_high);
  c_low: cover property (periph_irq_low);
  c_read: cover property (reg_rd ##1 reg_rdata != '0);
endmodule : periph_irq_monitor

bind peripheral_irq_flag_enable periph_irq_monitor #(.REG_WIDTH(REG_WIDTH)) i_mon (
  .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .events(events), .periph_irq(periph_irq),
  .periph_irq_high(periph_irq_high), .periph_irq_low(periph_irq_low));
`default_nettype wire

// ### verif/periph_source_model.sv
`timescale 1ns/1ps
`default_nettype none
module periph_source_model
  import periph_irq_pkg::*;
(
  // clock and reset
  input wire logic      mclk,
  input wire logic      rst,
  // bench requests, bit n fires flag n of {third, second}
  input wire logic [15:0] fire,
  input wire logic      use_cmp,
  // events toward the block
  output periph_events_t events
);
  logic [15:0] pulse_ff;   // one-cycle event pulses
  logic        use_cmp_ff; // capture or compare source
  logic [3:0]  lvl_ff;     // {rx full, tx empty, comparator 2, comparator 1}
  logic [3:0]  cc;         // capture/compare unit pulses

  always_ff @(posedge mclk) begin
    if (rst) begin
      pulse_ff <= 16'h0000;
      use_cmp_ff <= 1'b0;
      lvl_ff <= 4'h0;
    end else begin
      pulse_ff <= fire;
      use_cmp_ff <= use_cmp;
      lvl_ff <= lvl_ff ^ {fire[13:12], fire[6:5]};
    end
  end

  // unit order is 2, 3, 4, 5
  assign cc = {pulse_ff[10:8], pulse_ff[0]};
  assign events = {pulse_ff[7], lvl_ff[1:0], pulse_ff[4:1], pulse_ff[15:14], lvl_ff[3:2],
                   pulse_ff[11], use_cmp_ff ? 4'h0 : cc, use_cmp_ff ? cc : 4'h0};
endmodule : periph_source_model
`default_nettype wire

// ### verif/test_peripheral_irq_flag_enable.sv
`timescale 1ns/1ps
`default_nettype none
module test_peripheral_irq_flag_enable
  import periph_irq_pkg::*;
;
  logic           mclk, rst, reg_wr, reg_rd, use_cmp;
  logic [3:0]     reg_addr;
  logic [7:0]     reg_wdata, reg_rdata, flags_first;
  logic [7:0]     wval;
  logic [15:0]    fire;
  logic [23:0]    source_high_priority;
  logic           periph_irq, periph_irq_high, periph_irq_low;
  periph_events_t events;
  capcomp_mode_t  capcomp_mode [CAPCOMP_UNITS];
  int             miscompares, comparisons;

  // free-running clock
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  peripheral_irq_flag_enable i_dut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .events(events), .capcomp_mode(capcomp_mode),
    .flags_first(flags_first), .source_high_priority(source_high_priority), .periph_irq(periph_irq),
    .periph_irq_high(periph_irq_high), .periph_irq_low(periph_irq_low));
  periph_source_model i_src (.mclk(mclk), .rst(rst), .fire(fire), .use_cmp(use_cmp), .events(events));

  // compare and count
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask : chk

  task wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr

  // read, data stands in the cycle after the strobe
  task rd(input logic [3:0] a, input logic [7:0] v);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, v);
  endtask : rd

  // one event request, unit modes redrawn
  task pulse(input logic [15:0] v);
    @(posedge mclk);
    fire <= v;
    use_cmp <= 1'($urandom);
    foreach (capcomp_mode[k]) capcomp_mode[k] <= capcomp_mode_t'($urandom_range(3));
    @(posedge mclk);
    fire <= 16'h0000;
  endtask : pulse

  // requests as {low, high, any}
  task irq_chk(input logic [2:0] v);
    repeat (3) @(posedge mclk);
    #1 chk({5'h00, periph_irq_low, periph_irq_high, periph_irq}, {5'h00, v});
  endtask : irq_chk

  // flag expected after firing source i
  function automatic logic [7:0] exp_flag(input int i);
    int u;
    u = (i == 0) ? 0 : (i >= 8 && i <= 10) ? i - 7 : -1;
    if (u >= 0 && !((capcomp_mode[u] == MODE_CAPTURE && !use_cmp) || (capcomp_mode[u] == MODE_COMPARE && use_cmp)))
      return 8'h00;
    return 8'h01 << (i % 8);
  endfunction : exp_flag

  task results();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results

  initial begin
    rst = 1'b1;
    {reg_wr, reg_rd, use_cmp, reg_addr, reg_wdata, fire, flags_first, source_high_priority} = '0;
    foreach (capcomp_mode[k]) capcomp_mode[k] = MODE_OFF;
    miscompares = 0;
    comparisons = 0;
    void'($urandom(20));
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    // reset values, unmapped read and write
    for (int a = 0; a < 6; a++) rd(4'(a), 8'h00);
    rd(4'hF, 8'h00);
    wr(4'h9, 8'hFF);
    rd(OFF_IRQ_CONTROL, 8'h00);
    // enable registers hold random values
    for (int r = 2; r < 5; r++) begin
      wval = 8'($urandom);
      wr(4'(r), wval);
      rd(4'(r), wval);
      wr(4'(r), 8'h00);
    end
    // every source but the two uart levels sets its flag with all enables off, unit flags only in capture/compare mode
    for (int n = 0; n < 48; n++) begin
      if (n % 16 == 12 || n % 16 == 13) continue;
      pulse(16'h0001 << (n % 16));
      rd((n % 16 < 8) ? OFF_FLAGS_SECOND : OFF_FLAGS_THIRD, exp_flag(n % 16));
      wr((n % 16 < 8) ? OFF_FLAGS_SECOND : OFF_FLAGS_THIRD, 8'h00);
    end
    // uart flags follow levels, writes to them ignored
    pulse(16'h2000);
    wr(OFF_FLAGS_THIRD, 8'h30);
    rd(OFF_FLAGS_THIRD, 8'h20);
    pulse(16'h3000);
    rd(OFF_FLAGS_THIRD, 8'h10);
    pulse(16'h1000);
    // gating by global and priority enables
    wr(OFF_ENABLES_SECOND, 8'h02);
    pulse(16'h0002);
    irq_chk(3'b000);
    wr(OFF_IRQ_CONTROL, 8'h01);
    irq_chk(3'b101);
    wr(OFF_IRQ_CONTROL, 8'h02);
    irq_chk(3'b000);
    @(posedge mclk) source_high_priority <= 24'h000200;
    irq_chk(3'b011);
    rd(OFF_IRQ_STATUS, 8'h03);
    wr(OFF_FLAGS_SECOND, 8'h00);
    irq_chk(3'b000);
    @(posedge mclk) source_high_priority <= 24'h000000;
    wr(OFF_IRQ_CONTROL, 8'h01);
    // first enable register, one bit per source
    for (int k = 0; k < 8; k++) begin
      wr(OFF_ENABLES_FIRST, 8'h01 << k);
      @(posedge mclk) flags_first <= 8'h01 << k;
      irq_chk(3'b101);
      @(posedge mclk) flags_first <= ~(8'h01 << k);
      irq_chk(3'b000);
    end
    // third enable register gates its own sources
    wr(OFF_ENABLES_THIRD, 8'h08);
    pulse(16'h0800);
    irq_chk(3'b101);
    rd(OFF_IRQ_STATUS, 8'h05);
    results();
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    results();
  end
endmodule : test_peripheral_irq_flag_enable
`default_nettype wire
